// *** hw/pfq_pkg.sv ***
/*
  Package for the per-flow class scheduler and upstream class marker.
  Assumes one 50 MHz clock domain and an active-low asynchronous reset.
*/
package pfq_pkg;
  // ===========================================================
  // class codes
  localparam int         CODE_W       = 6;
  localparam logic [5:0] CODE_EXPEDIT = 6'h2E;
  localparam logic [5:0] CODE_BEST    = 6'h00;
  localparam int         FLOW_W       = 4;
  localparam int         DATA_W       = 32;
  localparam int         FIFO_DEPTH   = 32;
  // supported-code bitmap: bit n set means code n is scheduled
  localparam logic [63:0] SUPPORTED_MAP = 64'h0000_4000_0000_0001;
  localparam logic [5:0]  CODE_RESET    = 6'h00;

  typedef struct packed {
    logic [FLOW_W-1:0] flow;
    logic [DATA_W-1:0] data;
    logic              last;
  } pfq_word_t;

  typedef struct packed {
    logic [FLOW_W-1:0] flow;
    logic [5:0]        code;
  } pfq_cfg_t;
endpackage

// *** hw/pfq_sched.sv ***
/*
  Holds a small FIFO plus the downstream class scheduler and upstream
  class marker. Assumes packet words arrive tagged with the inner flow id
  and that the upstream class field position is given by a strobe.
*/
`timescale 1ns/1ps
`default_nettype none

// ===========================================================
// fifo
module pfq_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             wr;
  logic             rd;

  // honest full and empty from the count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;
  assign out_data  = mem[rp_reg];

  // storage has no reset, only pointers and fill count do
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (wr) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (rd) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// ===========================================================
// scheduler and marker
module pfq_sched #(
  parameter int NFLOW = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire pfq_pkg::pfq_cfg_t ds_cfg,
  input  wire logic              ds_cfg_we,
  input  wire pfq_pkg::pfq_cfg_t us_cfg,
  input  wire logic              us_cfg_we,
  output logic [63:0]            supported_codes,
  input  wire logic              ds_valid,
  output logic                   ds_ready,
  input  wire pfq_pkg::pfq_word_t ds_word,
  input  wire logic [5:0]        ds_hdr_class,
  output logic                   qam_valid,
  input  wire logic              qam_ready,
  output pfq_pkg::pfq_word_t     qam_word,
  output logic                   qam_expedited,
  input  wire logic              us_valid,
  output logic                   us_ready,
  input  wire pfq_pkg::pfq_word_t us_word,
  input  wire logic              us_class_here,
  output logic                   us_out_valid,
  input  wire logic              us_out_ready,
  output pfq_pkg::pfq_word_t     us_out_word
);
  localparam int WW = $bits(pfq_pkg::pfq_word_t);
  logic [5:0]      ds_code_reg [NFLOW];
  logic [5:0]      us_code_reg [NFLOW];
  logic [NFLOW-1:0] ds_hi;
  logic            ef_valid;
  logic            ef_ready;
  logic            be_valid;
  logic            be_ready;
  logic            ef_ovalid;
  logic            be_ovalid;
  logic            ef_take;
  logic [WW-1:0]   ef_data;
  logic [WW-1:0]   be_data;
  logic            in_hi;
  logic            lock_reg;
  logic            lock_hi_reg;
  logic            pick_hi;

  assign supported_codes = pfq_pkg::SUPPORTED_MAP;

  // per-flow code tables, one entry per flow
  genvar g;
  generate
    for (g = 0; g < NFLOW; g++) begin : g_flow
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ds_code_reg[g] <= pfq_pkg::CODE_RESET;
          us_code_reg[g] <= pfq_pkg::CODE_RESET;
        end else begin
          if (ds_cfg_we && ds_cfg.flow == pfq_pkg::FLOW_W'(g)) begin
            ds_code_reg[g] <= ds_cfg.code;
          end
          if (us_cfg_we && us_cfg.flow == pfq_pkg::FLOW_W'(g)) begin
            us_code_reg[g] <= us_cfg.code;
          end
        end
      end
      // class to queue, unsupported falls to best
      assign ds_hi[g] = (ds_code_reg[g] == pfq_pkg::CODE_EXPEDIT);
    end
  endgenerate

  // queue from flow id only; header class field ignored
  assign in_hi    = ds_hi[ds_word.flow];
  assign ef_valid = ds_valid && in_hi;
  assign be_valid = ds_valid && !in_hi;
  assign ds_ready = in_hi ? ef_ready : be_ready;

  pfq_fifo #(.WIDTH(WW), .DEPTH(pfq_pkg::FIFO_DEPTH)) u_ef (
    .clk(clk), .nrst(nrst), .in_valid(ef_valid), .in_ready(ef_ready),
    .in_data(ds_word), .out_valid(ef_ovalid), .out_ready(ef_take && qam_ready),
    .out_data(ef_data));
  pfq_fifo #(.WIDTH(WW), .DEPTH(pfq_pkg::FIFO_DEPTH)) u_be (
    .clk(clk), .nrst(nrst), .in_valid(be_valid), .in_ready(be_ready),
    .in_data(ds_word), .out_valid(be_ovalid),
    .out_ready(!ef_take && qam_ready), .out_data(be_data));

  // strict priority, held for a whole packet
  assign pick_hi = lock_reg ? lock_hi_reg : ef_ovalid;
  assign ef_take = pick_hi;
  assign qam_valid     = pick_hi ? ef_ovalid : be_ovalid;
  assign qam_word      = pick_hi ? ef_data : be_data;
  assign qam_expedited = pick_hi;

  // packet lock keeps words of one packet together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_reg    <= 1'b0;
      lock_hi_reg <= 1'b0;
    end else if (qam_valid && qam_ready) begin
      lock_reg    <= !qam_word.last;
      lock_hi_reg <= pick_hi;
    end
  end

  // mark upstream class field, no scheduling effect
  assign us_ready = us_out_ready || !us_out_valid;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      us_out_valid <= 1'b0;
      us_out_word  <= '0;
    end else if (us_ready) begin
      us_out_valid <= us_valid;
      us_out_word  <= us_word;
      if (us_class_here) begin
        us_out_word.data[5:0] <= us_code_reg[us_word.flow];
      end
    end
  end

  AST_EF_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    (!lock_reg && ef_ovalid) |-> qam_expedited)
    else $error("best effort served over waiting expedited");

  AST_US_MARK: assert property (@(posedge clk) disable iff (!nrst)
    (us_ready && us_valid && us_class_here && !us_cfg_we) |=>
    (us_out_word.data[5:0] == us_code_reg[us_out_word.flow]))
    else $error("upstream class field not marked");

  AST_BE_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
    (ds_valid && ds_code_reg[ds_word.flow] != pfq_pkg::CODE_EXPEDIT)
    |-> (!ef_valid && be_valid))
    else $error("non expedited flow sent to priority queue");

  // a code write lands in its flow entry next cycle
  AST_CODE_KEEP: assert property (@(posedge clk) disable iff (!nrst)
    ds_cfg_we |=>
    (ds_code_reg[$past(ds_cfg.flow)] == $past(ds_cfg.code)))
    else $error("downstream class code not stored");

  // an expedited header class never steers a best effort flow
  AST_HDR_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    (ds_valid && ds_hdr_class == pfq_pkg::CODE_EXPEDIT && !in_hi)
    |-> (!ef_valid && ds_ready == be_ready))
    else $error("header class field steered the queue choice");

  // a started packet keeps its class until its last word
  AST_PKT_WHOLE: assert property (@(posedge clk) disable iff (!nrst)
    (qam_valid && qam_ready && !qam_word.last) |=>
    (qam_expedited == $past(qam_expedited)))
    else $error("packet interleaved on the channel output");

  // words without the class strobe pass through untouched
  AST_US_PASS: assert property (@(posedge clk) disable iff (!nrst)
    (us_ready && us_valid && !us_class_here) |=>
    (us_out_valid && us_out_word == $past(us_word)))
    else $error("unstrobed upstream word altered");
endmodule

`default_nettype wire

// *** verification/pfq_sink.sv ***
/* Sink model for one scheduler output.
   Assumes one clock; ready drops while stall is high. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// sink
module pfq_sink (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               stall,
  input  wire logic               valid,
  output logic                    ready,
  input  wire pfq_pkg::pfq_word_t word,
  input  wire logic               exp,
  output logic [7:0]              n_got,
  output pfq_pkg::pfq_word_t      got_word,
  output logic                    got_exp
);
  // stalls on command, like a busy channel
  assign ready = !stall;
  // keep only the newest word, the bench checks as it goes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_got    <= 8'h00;
      got_word <= '0;
      got_exp  <= 1'b0;
    end else if (valid && ready) begin
      n_got    <= n_got + 8'h01;
      got_word <= word;
      got_exp  <= exp;
    end
  end
endmodule
`default_nettype wire

// *** verification/pfq_sched_tb.sv ***
/* Bench for the class scheduler and marker.
   Assumes pfq_sink stands on both outputs. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
// ==========
// bench
module pfq_sched_tb;
  logic               clk, nrst, ds_cfg_we, us_cfg_we, ds_valid, ds_ready;
  logic               qam_valid, qam_ready, qam_expedited, qam_stall, q_exp;
  logic               us_valid, us_ready, us_class_here, us_out_valid;
  logic               us_out_ready, u_exp;
  logic [5:0]         ds_hdr_class;
  logic [7:0]         q_n, u_n;
  logic [63:0]        supported_codes;
  pfq_pkg::pfq_cfg_t  ds_cfg, us_cfg;
  pfq_pkg::pfq_word_t ds_word, us_word, qam_word, us_out_word, q_got, u_got;
  int                 failures, comparisons, k;
  pfq_sched u_pfq_sched (.clk(clk), .nrst(nrst), .ds_cfg(ds_cfg),
    .ds_cfg_we(ds_cfg_we), .us_cfg(us_cfg), .us_cfg_we(us_cfg_we),
    .supported_codes(supported_codes), .ds_valid(ds_valid),
    .ds_ready(ds_ready), .ds_word(ds_word), .ds_hdr_class(ds_hdr_class),
    .qam_valid(qam_valid), .qam_ready(qam_ready), .qam_word(qam_word),
    .qam_expedited(qam_expedited), .us_valid(us_valid),
    .us_ready(us_ready), .us_word(us_word), .us_class_here(us_class_here),
    .us_out_valid(us_out_valid), .us_out_ready(us_out_ready),
    .us_out_word(us_out_word));
  pfq_sink u_pfq_sink_q (.clk(clk), .nrst(nrst), .stall(qam_stall),
    .valid(qam_valid), .ready(qam_ready), .word(qam_word),
    .exp(qam_expedited), .n_got(q_n), .got_word(q_got), .got_exp(q_exp));
  pfq_sink u_pfq_sink_u (.clk(clk), .nrst(nrst), .stall(1'b0),
    .valid(us_out_valid), .ready(us_out_ready), .word(us_out_word),
    .exp(1'b0), .n_got(u_n), .got_word(u_got), .got_exp(u_exp));
  // free-running 50 MHz clock
  always #10 clk = ~clk;
  task wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cfg(input logic up, input logic [3:0] f, input logic [5:0] c);
    @(negedge clk);
    ds_cfg = '{f, c};
    us_cfg = '{f, c};
    ds_cfg_we = !up;
    us_cfg_we = up;
    @(negedge clk);
    ds_cfg_we = 1'b0;
    us_cfg_we = 1'b0;
  endtask
  // one word with its last flag, held until ready seen at the edge
  task ds_put(input logic [3:0] f, input logic [31:0] d, input logic [5:0] h,
              input logic l);
    @(negedge clk);
    ds_valid = 1'b1;
    ds_word = '{f, d, l};
    ds_hdr_class = h;
    #1 while (ds_ready !== 1'b1) @(negedge clk) #1;
    @(negedge clk);
    ds_valid = 1'b0;
  endtask
  task wait_q(input logic [7:0] n);
    repeat (200) if (q_n < n) @(negedge clk);
    // a word that never shows counts as a failure by itself
    if (q_n < n) failures++;
  endtask
  task t_caps;
    `CHK(supported_codes[46], 1'b1)
    `CHK(supported_codes[0], 1'b1)
    `CHK(supported_codes, pfq_pkg::SUPPORTED_MAP)
  endtask
  // queued behind a stall so the arbiter has a real choice
  task t_prio;
    @(negedge clk);
    qam_stall = 1'b1;
    // map flow on 46, the rest 0
    cfg(1'b0, 4'h2, 6'h2E);
    cfg(1'b0, 4'h1, 6'h00);
    // each flow its own code; an assured level
    cfg(1'b0, 4'h3, 6'h0A);
    cfg(1'b1, 4'h1, 6'h2E);
    ds_put(4'h1, 32'h1111_1111, 6'h2E, 1'b1);
    ds_put(4'h3, 32'h3333_3333, 6'h2E, 1'b1);
    ds_put(4'h2, 32'h2222_2222, 6'h00, 1'b1);
    @(negedge clk);
    qam_stall = 1'b0;
    wait_q(8'h01);
    `CHK(q_got.flow, 4'h2)
    `CHK(q_exp, 1'b1)
    wait_q(8'h02);
    `CHK(q_got.flow, 4'h1)
    `CHK(q_exp, 1'b0)
    wait_q(8'h03);
    `CHK(q_got.flow, 4'h3)
    `CHK(q_exp, 1'b0)
  endtask
  // fill one flow queue until refused, then drain it
  task t_fill;
    @(negedge clk);
    qam_stall = 1'b1;
    k = 0;
    ds_valid = 1'b1;
    ds_word = '{4'h4, 32'h0000_0000, 1'b1};
    #1 while (ds_ready === 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
      ds_word.data = k;
      #1;
    end
    ds_valid = 1'b0;
    `CHK(k, 32)
    @(negedge clk);
    qam_stall = 1'b0;
    wait_q(8'h23);
    `CHK(q_got.data, 32'h0000_001F)
  endtask
  // a started best effort packet finishes before a later expedited word
  task t_lock;
    logic [7:0] base;
    base = q_n;
    @(negedge clk);
    qam_stall = 1'b1;
    ds_put(4'h1, 32'hA0A0_A0A0, 6'h00, 1'b0);
    ds_put(4'h1, 32'hB0B0_B0B0, 6'h00, 1'b1);
    // one ready edge lets only the first word out
    @(negedge clk);
    qam_stall = 1'b0;
    @(negedge clk);
    qam_stall = 1'b1;
    `CHK(q_n, base + 8'h01)
    ds_put(4'h2, 32'hC0C0_C0C0, 6'h00, 1'b1);
    @(negedge clk);
    qam_stall = 1'b0;
    wait_q(base + 8'h02);
    `CHK(q_got.data, 32'hB0B0_B0B0)
    `CHK(q_exp, 1'b0)
    wait_q(base + 8'h03);
    `CHK(q_got.data, 32'hC0C0_C0C0)
    `CHK(q_exp, 1'b1)
  endtask
  // one upstream word on flow 5, held until ready seen at the edge
  task us_put(input logic [31:0] d, input logic here);
    @(negedge clk);
    us_valid = 1'b1;
    us_class_here = here;
    us_word = '{4'h5, d, 1'b1};
    #1 while (us_ready !== 1'b1) @(negedge clk) #1;
    @(negedge clk);
    us_valid = 1'b0;
    us_class_here = 1'b0;
  endtask
  task t_mark;
    cfg(1'b1, 4'h5, 6'h3F);
    us_put(32'hABCD_EF00, 1'b1);
    repeat (200) if (u_n < 8'h01) @(negedge clk);
    `CHK(u_got.data[5:0], 6'h3F)
    `CHK(u_got.data, 32'hABCD_EF3F)
    // unstrobed words keep their low bits
    us_put(32'h1234_5678, 1'b0);
    repeat (200) if (u_n < 8'h02) @(negedge clk);
    `CHK(u_n, 8'h02)
    `CHK(u_got.data, 32'h1234_5678)
  endtask
  // watchdog well past the expected run
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
  initial begin
    {clk, nrst, ds_cfg_we, us_cfg_we, ds_valid, us_valid} = 6'h00;
    {qam_stall, us_class_here, ds_hdr_class} = 8'h00;
    {ds_cfg, us_cfg, ds_word, us_word} = '0;
    failures = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_caps;
    t_prio;
    t_fill;
    t_lock;
    t_mark;
    wrap_up;
  end
endmodule
`default_nettype wire
